/* File: charger_status_fault_regs_test.sv */
module charger_status_fault_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] lvl = 4'h0;
  logic dn = 1'b0, pk = 1'b0, otl = 1'b0, oth = 1'b0, psd = 1'b1, ien = 1'b0, chg = 1'b0;
  logic [2:0] cc = 3'h0, tc = 3'h0, bc = 3'h0;
  logic [11:0] mv = 12'hc00;
  logic [16:0] s = 17'd99120;
  logic wr, rd, shut, irq;
  logic [7:0] addr, wd, rdata;
  int n_mismatch = 0;
  int n_compared = 0;
  always #2.5 clk_sys = ~clk_sys;
  csf_host h (.clk_sys(clk_sys), .reg_rdata(rdata), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd));
  csf_regs dut (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .input_overvoltage_pin(lvl[3]),
    .input_valid_pin(lvl[2]), .input_current_limited_pin(lvl[1]), .die_thermal_limit_pin(lvl[0]),
    .charge_cycle_end_pin(dn), .charger_state_code(cc), .thermistor_state_code(tc), .battery_state_code(bc),
    .inductor_peak_event(pk), .overtemp_low_pin(otl), .overtemp_high_pin(oth), .battery_sense_mv(mv),
    .charging(chg), .peak_shutdown_disable(psd), .charger_mode_irq_enable(ien), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata), .peak_shutdown(shut), .charger_mode_irq(irq));
  ////////////////////////////////////////////////////////////////
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    lfsr = {v[15:0], v[16] ^ v[13]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    h.rd(a, d);
    chk(d, e);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      pk = 1'b1;
      repeat (2) @(negedge clk_sys);
      pk = 1'b0;
      repeat (2) @(negedge clk_sys);
    end
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    rc(8'h10, 8'h84);
    for (int i = 0; i < 8; i++) begin
      s = lfsr(s);
      lvl = s[3:0];
      tc = s[6:4];
      ien = s[7];
      chg = s[8];
      mv = 12'hb00 + 12'(s[15:8]);
      // every step changes the code, so the mode flag must follow the enable
      cc = 3'(7 - i);
      bc = 3'(i);
      repeat (4) @(negedge clk_sys);
      chk({7'h0, irq}, {7'h0, ien});
      rc(8'h0b, {lvl, 1'b0, cc});
      rc(8'h0c, {tc, 2'b00, bc});
    end
    dn = 1'b1;
    repeat (4) @(negedge clk_sys);
    dn = 1'b0;
    h.wr(8'h0b, 8'h00);
    rc(8'h0b, {lvl, 1'b1, cc});
    h.wr(8'h10, 8'hff);
    rc(8'h10, 8'he7);
    rc(8'h55, 8'h00);
    rc(8'h0d, 8'h00);
    otl = 1'b1;
    oth = 1'b1;
    repeat (6) @(negedge clk_sys);
    otl = 1'b0;
    oth = 1'b0;
    repeat (4) @(negedge clk_sys);
    h.wr(8'h0d, 8'hf1);
    rc(8'h0d, 8'h02);
    pulses(3);
    rc(8'h0c, {tc, 2'b00, bc});
    pulses(1);
    rc(8'h0c, {tc, 2'b10, bc});
    rc(8'h0d, 8'h06);
    chk({7'h0, shut}, 8'h00);
    h.wr(8'h0d, 8'h04);
    rc(8'h0d, 8'h02);
    psd = 1'b0;
    pulses(4);
    chk({7'h0, shut}, 8'h01);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    rc(8'h0d, 8'h00);
    rc(8'h10, 8'h84);
    chg = 1'b1;
    mv = 12'h100;
    repeat (20) @(negedge clk_sys);
    rc(8'h0d, 8'h00);
    chg = 1'b0;
    end_sim();
  end
endmodule

/* File: csf_host.sv */
module csf_host (
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    // released data must not look valid
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

/* File: csf_monitor.sv */
module csf_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] charger_state_code,
  input wire logic [2:0] thermistor_state_code,
  input wire logic [2:0] battery_state_code,
  input wire logic overtemp_high_pin,
  input wire logic peak_shutdown_disable,
  input wire logic charger_mode_irq_enable,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic peak_shutdown,
  input wire logic charger_mode_irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_cfg_wr;
    reg_wr && reg_addr == 8'h10 ##1 reg_addr == 8'h10 && !reg_wr;
  endsequence
  // five edges covers the two-stage sync plus the flag register
  sequence s_ot_high;
    overtemp_high_pin [*5] ##0 reg_addr == 8'h0d;
  endsequence
  ////////////////////////////////////////////////////////////////
  AST_RST_ZERO: assert property (disable iff (1'b0) rst |=> reg_rdata == 8'h00)
    else $error("read data not cleared by reset");
  AST_CHG_CODE: assert property (reg_addr == 8'h0b |=> reg_rdata[2:0] == $past(charger_state_code))
    else $error("charger code wrong");
  AST_STAT_TWO: assert property (reg_addr == 8'h0c |=>
    reg_rdata[7:5] == $past(thermistor_state_code) && reg_rdata[3:0] == {1'b0, $past(battery_state_code)})
    else $error("status two wrong");
  AST_UNMAPPED: assert property (!(reg_addr inside {8'h0b, 8'h0c, 8'h0d, 8'h10}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CFG_WR: assert property (s_cfg_wr |=> reg_rdata == ($past(reg_wdata, 2) & 8'he7))
    else $error("config write wrong");
  AST_OT_HIGH: assert property (s_ot_high |=> reg_rdata[0])
    else $error("high overtemp fault missing");
  AST_IRQ_SET: assert property (charger_mode_irq_enable && $changed(charger_state_code) && !$past(rst)
    |=> charger_mode_irq || !charger_mode_irq_enable)
    else $error("mode irq missing");
  AST_SHUTDOWN: assert property ($rose(peak_shutdown) |-> !$past(peak_shutdown_disable))
    else $error("shutdown while disabled");
endmodule
bind csf_regs csf_monitor mon (.clk_sys(clk_sys), .rst(rst), .charger_state_code(charger_state_code),
  .thermistor_state_code(thermistor_state_code), .battery_state_code(battery_state_code),
  .overtemp_high_pin(overtemp_high_pin), .peak_shutdown_disable(peak_shutdown_disable),
  .charger_mode_irq_enable(charger_mode_irq_enable), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .peak_shutdown(peak_shutdown), .charger_mode_irq(charger_mode_irq));

/* File: csf_pkg.sv */
package csf_pkg;
  // register offsets
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h0b;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h0c;
  localparam logic [7:0] ADDR_FAULT = 8'h0d;
  localparam logic [7:0] ADDR_SHORT_CFG = 8'h10;
  // field positions
  localparam int BIT_OV = 7;
  localparam int BIT_VALID = 6;
  localparam int BIT_ILIM = 5;
  localparam int BIT_THERM = 4;
  localparam int BIT_DONE = 3;
  localparam int BIT_PEAK_STAT = 4;
  localparam int BIT_F_SHORT = 3;
  localparam int BIT_F_PEAK = 2;
  localparam int BIT_F_OT_LOW = 1;
  localparam int BIT_F_OT_HIGH = 0;
  localparam int POS_TIMEOUT = 5;
  localparam int POS_THRESH = 0;
  // reset values
  localparam logic [2:0] RST_TIMEOUT = 3'h4;
  localparam logic [2:0] RST_THRESH = 3'h4;
  localparam logic [3:0] RST_FAULT = 4'h0;
  localparam logic RST_PEAK_SD_DIS = 1'b1;
  // peak events in succession that count as a peak limit condition
  localparam logic [2:0] PEAK_RUN = 3'h4;
  // battery-short timeout table, seconds, codes 000..111
  localparam int SHORT_TO_SEC [8] = '{1, 2, 4, 10, 30, 60, 120, 180};
  localparam longint CLK_HZ = 200000000;
  // one-second tick count at the system clock rate
  localparam longint SEC_CYCLES = CLK_HZ * 1;
  // threshold table, millivolts
  localparam int SHORT_TH_MV [8] = '{2000, 2100, 2200, 2300, 2400, 2500, 2600, 2700};
  // charger state codes
  typedef enum logic [2:0] {
    CSF_CHG_OFF = 3'b000,
    CSF_CHG_TRICKLE = 3'b001,
    CSF_CHG_FAST_CC = 3'b010,
    CSF_CHG_FAST_CV = 3'b011,
    CSF_CHG_COMPLETE = 3'b100,
    CSF_CHG_SUSPEND = 3'b101,
    CSF_CHG_TIMEOUT = 3'b110,
    CSF_CHG_DETECT = 3'b111
  } csf_chg_state_t;
endpackage

/* File: csf_regs.sv */
// Function
// RL1 - status one bit 7 shows input overvoltage, bit 6 input valid
// RL2 - bit 5 shows input current limited by blocking switch
// RL3 - bit 4 shows charge current reduced by die temperature
// RL4 - bit 3 latches charge done, survives recharge threshold crossing
// RL5 - charger code 000 off through 100 complete
// RL6 - charger code 101 suspend, 110 timer expired, 111 detection
// RL7 - status two bits 7:5 carry thermistor state code
// RL8 - bit 4 set after four or more successive peak events
// RL9 - status two bits 2:0 carry battery state code
// RL10 - fault bit 3 set on battery short; bits 7:4 unused
// RL11 - fault bit 2 set on inductor peak fault
// RL12 - fault bit 1 at 130 degrees, bit 0 at 140 degrees
// RL13 - fault bits clear only by writing one or supply cycling
// RL14 - config bits 7:5 choose short timeout, reset code 100
// RL15 - config bits 2:0 choose short threshold, reset code 100
// RL16 - with shutdown disable high, peak events only flag status
// RL17 - each charger code change raises enabled mode interrupt flag
// RL18 - battery short fault after sense below threshold past timeout
// RL19 - unused bits read zero, writes to read-only registers ignored
module csf_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic input_overvoltage_pin,
  input wire logic input_valid_pin,
  input wire logic input_current_limited_pin,
  input wire logic die_thermal_limit_pin,
  input wire logic charge_cycle_end_pin,
  input wire logic [2:0] charger_state_code,
  input wire logic [2:0] thermistor_state_code,
  input wire logic [2:0] battery_state_code,
  input wire logic inductor_peak_event,
  input wire logic overtemp_low_pin,
  input wire logic overtemp_high_pin,
  input wire logic [11:0] battery_sense_mv,
  input wire logic charging,
  input wire logic peak_shutdown_disable,
  input wire logic charger_mode_irq_enable,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic peak_shutdown,
  output logic charger_mode_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: analog comparators are asynchronous to clk_sys
  logic [7:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic ov_s, valid_s, ilim_s, therm_s, done_s, peak_s, otl_s, oth_s;

  always_comb begin
    sync1_d = {input_overvoltage_pin, input_valid_pin, input_current_limited_pin, die_thermal_limit_pin,
               charge_cycle_end_pin, inductor_peak_event, overtemp_low_pin, overtemp_high_pin};
    sync2_d = sync1_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else if (clk_en) begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  assign {ov_s, valid_s, ilim_s, therm_s, done_s, peak_s, otl_s, oth_s} = sync2_q;

  ////////////////////////////////////////////////////////////////////////////
  // status state, fault flags, configuration
  logic done_q, done_d;
  logic peak_prev_q, peak_prev_d;
  logic [2:0] peak_run_q, peak_run_d;
  logic peak_stat_q, peak_stat_d;
  logic [3:0] fault_q, fault_d;
  logic [2:0] timeout_sel_q, timeout_sel_d;
  logic [2:0] thresh_sel_q, thresh_sel_d;
  logic [2:0] chg_prev_q, chg_prev_d;
  logic irq_q, irq_d;
  logic shut_q, shut_d;
  logic [7:0] sec_cnt_q, sec_cnt_d;
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic [7:0] rdata_q, rdata_d;
  logic peak_rise, short_low, short_hit, sec_tick;
  logic [3:0] fault_set, fault_clr;
  logic wr_fault, wr_cfg, rd_status_one;
  logic [7:0] status_one_word, status_two_word, fault_word, cfg_word;

  function automatic logic [11:0] thresh_mv(input logic [2:0] sel);
    thresh_mv = 12'(csf_pkg::SHORT_TH_MV[sel]);
  endfunction

  function automatic logic [7:0] timeout_sec(input logic [2:0] sel);
    timeout_sec = 8'(csf_pkg::SHORT_TO_SEC[sel]);
  endfunction

  // address match, shared by the write, clear and read decoders
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
    addr_is = (addr == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus decode; strobes are one cycle wide
  assign wr_fault = reg_wr && addr_is(reg_addr, csf_pkg::ADDR_FAULT);
  assign wr_cfg = reg_wr && addr_is(reg_addr, csf_pkg::ADDR_SHORT_CFG);
  assign rd_status_one = reg_rd && addr_is(reg_addr, csf_pkg::ADDR_STATUS_ONE);

  ////////////////////////////////////////////////////////////////////////////
  // peak event counting
  always_comb begin
    peak_rise = peak_s & ~peak_prev_q;
    peak_prev_d = peak_s;
    // RL8 successive peak count
    peak_run_d = peak_run_q;
    if (peak_rise && peak_run_q != csf_pkg::PEAK_RUN) begin
      peak_run_d = peak_run_q + 3'h1;
    end
    // a cleared peak fault restarts the run; events count however far apart they are
    if (fault_clr[csf_pkg::BIT_F_PEAK]) begin
      peak_run_d = 3'h0;
    end
    peak_stat_d = (peak_run_d == csf_pkg::PEAK_RUN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // shutdown latch
  always_comb begin
    // RL16 shutdown only when not disabled; sticky until the supply cycles
    shut_d = shut_q | (peak_stat_d & ~peak_shutdown_disable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // charge done latch
  always_comb begin
    // RL4 sticky done latch; no bus clear, only a supply cycle
    done_d = done_q | done_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // battery short timer
  always_comb begin
    // RL18 battery short timer, one-second ticks
    // ticks are counted from the first low cycle, so the fault lands one clock after the timeout
    short_low = charging && (battery_sense_mv < thresh_mv(thresh_sel_q));
    sec_tick = (tick_cnt_q == 32'(csf_pkg::SEC_CYCLES - 1));
    tick_cnt_d = (!short_low || sec_tick) ? 32'h0 : tick_cnt_q + 32'h1;
    sec_cnt_d = sec_cnt_q;
    if (!short_low) begin
      sec_cnt_d = 8'h00;
    end else if (sec_tick && sec_cnt_q != 8'hff) begin
      sec_cnt_d = sec_cnt_q + 8'h01;
    end
    short_hit = short_low && (sec_cnt_q >= timeout_sec(timeout_sel_q));
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault flags
  always_comb begin
    // RL10 RL11 RL12 fault set sources
    fault_set = 4'h0;
    fault_set[csf_pkg::BIT_F_SHORT] = short_hit;
    fault_set[csf_pkg::BIT_F_PEAK] = peak_stat_d & ~peak_stat_q;
    fault_set[csf_pkg::BIT_F_OT_LOW] = otl_s;
    fault_set[csf_pkg::BIT_F_OT_HIGH] = oth_s;
    // RL13 write one clears, set wins
    // set wins so a short or overtemp event in the clearing cycle is never lost
    fault_clr = wr_fault ? reg_wdata[3:0] : 4'h0;
    fault_d = (fault_q & ~fault_clr) | fault_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // short detection configuration
  always_comb begin
    // RL14 RL15 config writes; unused bits 4:3 not stored
    timeout_sel_d = timeout_sel_q;
    thresh_sel_d = thresh_sel_q;
    if (wr_cfg) begin
      timeout_sel_d = reg_wdata[csf_pkg::POS_TIMEOUT +: 3];
      thresh_sel_d = reg_wdata[csf_pkg::POS_THRESH +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // charger mode change flag
  always_comb begin
    // RL17 mode change interrupt, held until a status one read
    chg_prev_d = charger_state_code;
    irq_d = irq_q;
    if (rd_status_one) begin
      irq_d = 1'b0;
    end
    // a change in the reading cycle wins, so the host cannot miss it
    if (charger_state_code != chg_prev_q) begin
      irq_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register words as the host sees them
  always_comb begin
    status_one_word = 8'h00;
    // RL1 RL2 RL3 live flags
    status_one_word[csf_pkg::BIT_OV] = ov_s;
    status_one_word[csf_pkg::BIT_VALID] = valid_s;
    status_one_word[csf_pkg::BIT_ILIM] = ilim_s;
    status_one_word[csf_pkg::BIT_THERM] = therm_s;
    status_one_word[csf_pkg::BIT_DONE] = done_q;
    // RL5 RL6 charger code
    status_one_word[2:0] = charger_state_code;
    status_two_word = 8'h00;
    // RL7 RL9 coded states
    status_two_word[7:5] = thermistor_state_code;
    status_two_word[csf_pkg::BIT_PEAK_STAT] = peak_stat_q;
    status_two_word[2:0] = battery_state_code;
    fault_word = 8'h00;
    fault_word[3:0] = fault_q;
    cfg_word = 8'h00;
    cfg_word[csf_pkg::POS_TIMEOUT +: 3] = timeout_sel_q;
    cfg_word[csf_pkg::POS_THRESH +: 3] = thresh_sel_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data
  always_comb begin
    // RL19 read mux; unused bits and unmapped addresses read zero
    // registered every cycle, so the host never sees a half-settled byte
    rdata_d = 8'h00;
    case (reg_addr)
      csf_pkg::ADDR_STATUS_ONE: begin
        rdata_d = status_one_word;
      end
      csf_pkg::ADDR_STATUS_TWO: begin
        rdata_d = status_two_word;
      end
      csf_pkg::ADDR_FAULT: begin
        rdata_d = fault_word;
      end
      csf_pkg::ADDR_SHORT_CFG: begin
        rdata_d = cfg_word;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; reset models a supply power cycle
  // peak counting
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      peak_prev_q <= 1'b0;
      peak_run_q <= 3'h0;
      peak_stat_q <= 1'b0;
    end else if (clk_en) begin
      peak_prev_q <= peak_prev_d;
      peak_run_q <= peak_run_d;
      peak_stat_q <= peak_stat_d;
    end
  end

  // shutdown
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shut_q <= 1'b0;
    end else if (clk_en) begin
      shut_q <= shut_d;
    end
  end

  // charge done
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= done_d;
    end
  end

  // short timer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sec_cnt_q <= 8'h00;
      tick_cnt_q <= 32'h0;
    end else if (clk_en) begin
      sec_cnt_q <= sec_cnt_d;
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // fault flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_q <= csf_pkg::RST_FAULT;
    end else if (clk_en) begin
      fault_q <= fault_d;
    end
  end

  // configuration
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timeout_sel_q <= csf_pkg::RST_TIMEOUT;
      thresh_sel_q <= csf_pkg::RST_THRESH;
    end else if (clk_en) begin
      timeout_sel_q <= timeout_sel_d;
      thresh_sel_q <= thresh_sel_d;
    end
  end

  // mode change flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chg_prev_q <= 3'h0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      chg_prev_q <= chg_prev_d;
      irq_q <= irq_d;
    end
  end

  // read data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign peak_shutdown = shut_q;
  assign charger_mode_irq = irq_q & charger_mode_irq_enable;

endmodule
